/* File: core/reset_watchdog_sleep_ctrl.sv */
// reset, watchdog, sleep and supply-monitor control block with apb registers
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ns
// Behaviour
// R01: power-on loads status register with 00010000
// R02: hold cpu about 20 ms after power-on
// R03: power-on flag set by reset, software-clear only
// R04: clearing power-on flag enables watchdog permanently
// R05: sleep timer on slow clock raises interrupt
// R06: three timer overflows cause watchdog reset
// R07: clear write resets watchdog; 0x38 also timer
// R08: sleep bit halts cpu until interrupt/reset
// R09: detector duty-cycled while asleep
// R10: slow oscillator keeps running, optional low power
// R11: unmasked pending interrupt wakes regardless of enable
// R12: wake only while stop bit clear
// R13: sleep forces internal clock; recover in three ticks
// R14: external oscillator left running during sleep
// R15: resume at next instruction before interrupt service
// R16: sleep timer interrupt also fires while awake
// R17: level field selects precision reset threshold
// R18: level 11 disables precision reset, status only
// R19: threshold select picks one of eight levels
// R20: supply drop below trip reasserts power-on reset
// R21: duty field codes 128, 512, 32, 8 ticks
// R22: power-on clears sleep timer and watchdog
module reset_watchdog_sleep_ctrl
  import rst_wdt_pkg::*;
#(
  parameter int HOLDOFF = HOLDOFF_CYCLES,
  parameter int TIMER_W = 16
) (
  input wire logic sys_clk,
  input wire logic reset,
  // slow oscillator, supply and interrupt request pins asynchronous; global enable used unsynchronised
  input wire logic slowTick,
  input wire logic supplyBelowPor,
  input wire logic irqPending,
  input wire logic globalIrqEnable,
  // apb register bus, low data byte only
  input wire logic [7:0] pwdata,
  input wire logic [15:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // cpu control and clock source outputs
  output logic cpuReset,
  output logic cpuRun,
  output logic resumeNext,
  output logic cpuClockSelect,
  output logic extOscEnable,
  output logic slowOscLowPower,
  output logic sleepTimerIrq,
  // supply monitor configuration outputs
  output logic detectorOn,
  output logic [1:0] precisionResetLevel,
  output logic precisionResetEnable,
  output logic [2:0] lvdThresholdSelect
);
  // elaboration checks: the hold-off counter needs at least one cycle,
  // and the longest sleep period reads timer bits 13:0
  initial begin
    if (HOLDOFF < 1) begin
      $error("hold-off must be at least one cycle");
    end
    if (TIMER_W < 14) begin
      $error("sleep timer narrower than longest period");
    end
    if (TIMER_W > 24) begin
      $error("sleep timer wider than needed");
    end
  end

  // two-flop synchronisers for pins from other domains
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic tickPrev_q;
  always_ff @(posedge sys_clk) begin
    sync1_q <= {slowTick, supplyBelowPor, irqPending};
    sync2_q <= sync1_q;
    tickPrev_q <= sync2_q[2];
  end
  // one slow tick per rising edge of the slow oscillator
  wire tick = sync2_q[2] & ~tickPrev_q;
  wire supplyLow = sync2_q[1];
  wire irqSeen = sync2_q[0];

  // power-on reset: external reset or supply drop [R20]
  logic wdogReset_q;
  wire por = reset | supplyLow; // [R20]
  // watchdog reset restarts the cpu and timers, clears the sleep bit, sets the watchdog event flag, keeps the other registers
  wire anyReset = por | wdogReset_q;

  // apb decode
  wire access = psel & penable;
  wire wr = access & pwrite;
  wire [13:0] addr = paddr[13:0];
  function automatic logic hit(input logic [13:0] a, input logic [13:0] r);
    hit = (a == r);
  endfunction
  wire mapped = hit(addr, ADDR_WATCHDOG_CLEAR) | hit(addr, ADDR_LOW_VOLTAGE_CONTROL) |
                hit(addr, ADDR_SYSTEM_STATUS_CONTROL) | hit(addr, ADDR_DETECTOR_DUTY_TRIM) |
                hit(addr, ADDR_OSC_CONTROL_ZERO) | hit(addr, ADDR_WAKE_STATUS);
  wire wrClear = wr & hit(addr, ADDR_WATCHDOG_CLEAR);
  wire wrSsc = wr & hit(addr, ADDR_SYSTEM_STATUS_CONTROL);

  // status/control register
  logic powerOn_q;
  logic wdogEvent_q;
  logic sleep_q;
  logic stop_q;
  logic wdogEnable_q;
  cpu_state_t state_q;
  always_ff @(posedge sys_clk) begin
    if (por) begin
      powerOn_q <= SSC_RESET[SSC_POWER_ON_BIT]; // [R01] [R03]
      wdogEvent_q <= SSC_RESET[SSC_WDOG_EVENT_BIT]; // [R01]
      sleep_q <= SSC_RESET[SSC_SLEEP_BIT]; // [R01]
      stop_q <= SSC_RESET[SSC_STOP_BIT]; // [R01]
    end else begin
      // power-on flag: clear-only, a one written is ignored [R03]
      if (wrSsc && !pwdata[SSC_POWER_ON_BIT]) begin
        powerOn_q <= 1'b0; // [R03]
      end
      // watchdog event flag: set wins over a clear in the same cycle
      if (wdogReset_q) begin
        wdogEvent_q <= 1'b1;
      end else if (wrSsc && !pwdata[SSC_WDOG_EVENT_BIT]) begin
        wdogEvent_q <= 1'b0;
      end
      // sleep bit: set by software, dropped by wake-up or watchdog reset
      if (wdogReset_q) begin
        sleep_q <= 1'b0;
      end else if (wrSsc) begin
        sleep_q <= pwdata[SSC_SLEEP_BIT]; // [R08]
      end else if (state_q == ST_WAKE) begin
        sleep_q <= 1'b0;
      end
      // stop bit blocks wake-up while set [R12]
      if (wrSsc) begin
        stop_q <= pwdata[SSC_STOP_BIT]; // [R12]
      end
    end
  end

  // watchdog enable: sticky until power-on [R04]
  always_ff @(posedge sys_clk) begin
    if (por) begin
      wdogEnable_q <= 1'b0; // [R04]
    end else if (!powerOn_q) begin
      wdogEnable_q <= 1'b1; // [R04]
    end
  end

  // other registers
  logic [7:0] lvc_q;
  logic [7:0] duty_q;
  logic [7:0] osc_q;
  always_ff @(posedge sys_clk) begin
    if (por) begin
      lvc_q <= LVC_RESET;
      duty_q <= DUTY_RESET;
      osc_q <= OSC_RESET;
    end else if (wr) begin
      // reserved bits of the voltage and duty registers are kept at zero; oscillator control stores every bit
      if (hit(addr, ADDR_LOW_VOLTAGE_CONTROL)) begin
        lvc_q <= pwdata & LVC_MASK; // [R17] [R19]
      end
      if (hit(addr, ADDR_DETECTOR_DUTY_TRIM)) begin
        duty_q <= pwdata & DUTY_MASK; // [R21]
      end
      if (hit(addr, ADDR_OSC_CONTROL_ZERO)) begin
        osc_q <= pwdata; // [R10] [R14]
      end
    end
  end

  // sleep timer on slow ticks; period 2^(8+2*osc[4:3]) ticks [R05]
  logic [TIMER_W-1:0] timer_q;
  logic [1:0] wdog_q;
  logic overflow;
  always_comb begin
    case (osc_q[4:3])
      2'd0: overflow = &timer_q[7:0];
      2'd1: overflow = &timer_q[9:0];
      2'd2: overflow = &timer_q[11:0];
      default: overflow = &timer_q[13:0];
    endcase
  end
  wire expire = tick & overflow;
  always_ff @(posedge sys_clk) begin
    if (anyReset) begin
      timer_q <= '0; // [R22]
    end else if (wrClear && pwdata == CLEAR_BOTH_CODE) begin
      timer_q <= '0; // [R07]
    end else if (tick) begin
      // wraps to zero on the overflow that raises the request
      timer_q <= expire ? '0 : timer_q + 1'b1; // [R05] [R10]
    end
  end

  // watchdog counts overflows; three gives reset [R06]
  always_ff @(posedge sys_clk) begin
    if (anyReset) begin
      wdog_q <= 2'd0; // [R22]
      wdogReset_q <= 1'b0;
    end else if (wrClear) begin
      wdog_q <= 2'd0; // [R07]
      wdogReset_q <= 1'b0;
    end else begin
      // count only once enabled; the third overflow fires the reset
      if (expire && wdogEnable_q) begin
        wdog_q <= wdog_q + 2'd1; // [R06]
      end
      wdogReset_q <= wdogEnable_q && expire && (wdog_q == WDOG_LIMIT - 2'd1); // [R06]
    end
  end

  // sleep timer interrupt pulse, asleep or awake [R16]
  always_ff @(posedge sys_clk) begin
    if (anyReset) begin
      sleepTimerIrq <= 1'b0;
    end else begin
      sleepTimerIrq <= expire; // [R05] [R16]
    end
  end

  // cpu state: hold-off, run, sleep, clock recovery
  logic [31:0] hold_q;
  logic [1:0] recover_q;
  // last recovery tick: clock is stable again [R13] [R15]
  wire wakeDone = (state_q == ST_WAKE) && tick && (recover_q == 2'(OSC_RECOVER_SLOW - 1));
  always_ff @(posedge sys_clk) begin
    if (anyReset) begin
      state_q <= ST_HOLD;
      hold_q <= '0;
      recover_q <= '0;
    end else begin
      case (state_q)
        ST_HOLD: begin
          // cpu held while the supply settles [R02]
          hold_q <= hold_q + 32'd1;
          if (hold_q == 32'(HOLDOFF - 1)) begin
            state_q <= ST_RUN; // [R02]
          end
        end
        ST_RUN: begin
          if (sleep_q) begin
            state_q <= ST_SLEEP; // [R08]
          end
        end
        ST_SLEEP: begin
          // any unmasked request wakes while the stop bit is clear, enable flag ignored
          recover_q <= '0;
          if (irqSeen && !stop_q) begin
            state_q <= ST_WAKE; // [R11] [R12]
          end
        end
        ST_WAKE: begin
          // fast oscillator restarts; wait three slow ticks
          if (tick) begin
            recover_q <= recover_q + 2'd1;
          end
          if (wakeDone) begin
            state_q <= ST_RUN; // [R13]
          end
        end
        default: state_q <= ST_HOLD;
      endcase
    end
  end

  // detector duty cycle while asleep [R09]
  logic [9:0] duty_cnt_q;
  logic [9:0] dutyLen;
  always_comb begin
    case (duty_q[7:6])
      2'd0: dutyLen = 10'd128; // [R21]
      2'd1: dutyLen = 10'd512;
      2'd2: dutyLen = 10'd32;
      default: dutyLen = 10'd8;
    endcase
  end
  always_ff @(posedge sys_clk) begin
    if (anyReset || state_q != ST_SLEEP) begin
      duty_cnt_q <= '0;
      detectorOn <= 1'b1;
    end else if (tick) begin
      if (duty_cnt_q == dutyLen - 10'd1) begin
        duty_cnt_q <= '0;
        detectorOn <= ~detectorOn; // [R09]
      end else begin
        duty_cnt_q <= duty_cnt_q + 10'd1;
      end
    end
  end

  // cpu-facing outputs, registered
  always_ff @(posedge sys_clk) begin
    if (anyReset) begin
      cpuReset <= 1'b1;
      cpuRun <= 1'b0;
      resumeNext <= 1'b0;
      cpuClockSelect <= 1'b0;
      extOscEnable <= 1'b0;
      slowOscLowPower <= 1'b0;
    end else begin
      cpuReset <= (state_q == ST_HOLD); // [R02]
      // cpu runs from the wake-done cycle on, together with the resume pulse
      cpuRun <= ((state_q == ST_RUN) && !sleep_q) || wakeDone; // [R08] [R15]
      resumeNext <= wakeDone; // [R15]
      cpuClockSelect <= (state_q == ST_RUN) ? osc_q[1] : 1'b0; // [R13]
      extOscEnable <= osc_q[2]; // [R14]
      slowOscLowPower <= osc_q[7]; // [R10]
    end
  end

  // detector configuration outputs
  always_ff @(posedge sys_clk) begin
    if (por) begin
      precisionResetLevel <= 2'b00;
      precisionResetEnable <= 1'b1;
      lvdThresholdSelect <= 3'b000;
    end else begin
      precisionResetLevel <= lvc_q[5:4]; // [R17]
      precisionResetEnable <= lvc_q[5:4] != LEVEL_NO_RESET; // [R18]
      lvdThresholdSelect <= lvc_q[2:0]; // [R19]
    end
  end

  // read-back bytes of the status and wake registers
  logic [7:0] statusByte;
  logic [7:0] wakeByte;
  always_comb begin
    statusByte = 8'h00;
    statusByte[SSC_GIE_BIT] = globalIrqEnable;
    statusByte[SSC_WDOG_EVENT_BIT] = wdogEvent_q;
    statusByte[SSC_POWER_ON_BIT] = powerOn_q;
    statusByte[SSC_SLEEP_BIT] = sleep_q;
    statusByte[SSC_STOP_BIT] = stop_q;
    wakeByte = {4'h0, wdogEnable_q, wdog_q, state_q == ST_SLEEP};
  end

  // apb slave: one wait-free access phase, read data registered
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      prdata <= '0;
      // read data is fetched in the setup cycle and stands in the access cycle;
      // the write-only clear register and unmapped offsets read as zero
      if (psel && !penable && !pwrite) begin
        if (hit(addr, ADDR_SYSTEM_STATUS_CONTROL)) begin
          prdata <= {24'h000000, statusByte}; // [R01] [R03]
        end else if (hit(addr, ADDR_LOW_VOLTAGE_CONTROL)) begin
          prdata <= {24'h000000, lvc_q}; // [R17] [R19]
        end else if (hit(addr, ADDR_DETECTOR_DUTY_TRIM)) begin
          prdata <= {24'h000000, duty_q}; // [R21]
        end else if (hit(addr, ADDR_OSC_CONTROL_ZERO)) begin
          prdata <= {24'h000000, osc_q};
        end else if (hit(addr, ADDR_WAKE_STATUS)) begin
          prdata <= {24'h000000, wakeByte};
        end
      end
    end
  end
endmodule

/* File: common/rst_wdt_pkg.sv */
// package: register map, field layout and timing for reset/watchdog/sleep control
package rst_wdt_pkg;
  // apb byte addresses (printed offsets 0xE3/0x1E3 are not word aligned: kept as index)
  localparam logic [11:0] IDX_WATCHDOG_CLEAR = 12'h0E3;
  localparam logic [11:0] IDX_LOW_VOLTAGE_CONTROL = 12'h1E3;
  localparam logic [11:0] IDX_SYSTEM_STATUS_CONTROL = 12'h0FF;
  localparam logic [11:0] IDX_DETECTOR_DUTY_TRIM = 12'h1EB;
  localparam logic [11:0] IDX_OSC_CONTROL_ZERO = 12'h1E0;
  localparam logic [11:0] IDX_WAKE_STATUS = 12'h1F0;
  localparam logic [13:0] ADDR_WATCHDOG_CLEAR = {IDX_WATCHDOG_CLEAR, 2'b00};
  localparam logic [13:0] ADDR_LOW_VOLTAGE_CONTROL = {IDX_LOW_VOLTAGE_CONTROL, 2'b00};
  localparam logic [13:0] ADDR_SYSTEM_STATUS_CONTROL = {IDX_SYSTEM_STATUS_CONTROL, 2'b00};
  localparam logic [13:0] ADDR_DETECTOR_DUTY_TRIM = {IDX_DETECTOR_DUTY_TRIM, 2'b00};
  localparam logic [13:0] ADDR_OSC_CONTROL_ZERO = {IDX_OSC_CONTROL_ZERO, 2'b00};
  localparam logic [13:0] ADDR_WAKE_STATUS = {IDX_WAKE_STATUS, 2'b00};
  // status/control register layout and reset value
  localparam logic [7:0] SSC_RESET = 8'h10;
  localparam int SSC_STOP_BIT = 0;
  localparam int SSC_SLEEP_BIT = 3;
  localparam int SSC_POWER_ON_BIT = 4;
  localparam int SSC_WDOG_EVENT_BIT = 5;
  localparam int SSC_GIE_BIT = 7;
  localparam logic [7:0] LVC_RESET = 8'h00;
  localparam logic [7:0] LVC_MASK = 8'h37;
  localparam logic [7:0] DUTY_RESET = 8'h00;
  localparam logic [7:0] DUTY_MASK = 8'hC0;
  localparam logic [7:0] OSC_RESET = 8'h00;
  localparam logic [7:0] CLEAR_BOTH_CODE = 8'h38;
  localparam logic [1:0] LEVEL_NO_RESET = 2'b11;
  localparam logic [1:0] WDOG_LIMIT = 2'd3;
  localparam int OSC_RECOVER_SLOW = 3;
  // times
  localparam int CLK_HZ = 25_000_000;
  localparam int HOLDOFF_MS = 20;
  localparam int HOLDOFF_CYCLES = (CLK_HZ / 1000) * HOLDOFF_MS;
  typedef enum logic [1:0] {ST_HOLD, ST_RUN, ST_SLEEP, ST_WAKE} cpu_state_t;
endpackage

/* File: testbench/rwsc_checker_asserts.sv */
// checker: port assertions for reset, watchdog and sleep control
`timescale 1ns/1ns
module rwsc_checker (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic supplyBelowPor,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic cpuReset,
  input wire logic cpuRun,
  input wire logic resumeNext,
  input wire logic cpuClockSelect,
  input wire logic sleepTimerIrq,
  input wire logic [1:0] precisionResetLevel,
  input wire logic precisionResetEnable
);
  // one clock domain, all checks quiet during reset
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  a_apb_ready: assert property (psel && !penable |=> pready)
    else $error("ready not one cycle after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_err_data: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error answer with data");
  a_level_enable: assert property (precisionResetEnable == (precisionResetLevel != 2'b11))
    else $error("precision reset enable wrong");
  a_hold_cpu: assert property (cpuReset |-> !cpuRun)
    else $error("cpu runs while held");
  a_sleep_clock: assert property (!cpuRun && $past(!cpuRun) |-> !cpuClockSelect)
    else $error("clock select not internal");
  a_supply_drop: assert property (supplyBelowPor [*5] |-> cpuReset)
    else $error("supply drop without reset");
  a_resume_run: assert property (resumeNext |-> cpuRun ##1 !resumeNext)
    else $error("resume pulse wrong");
  a_irq_pulse: assert property (sleepTimerIrq |=> !sleepTimerIrq)
    else $error("timer request too long");
endmodule
bind reset_watchdog_sleep_ctrl rwsc_checker chk (.*);

/* File: testbench/reset_watchdog_sleep_ctrl_test.sv */
// testbench: registers, sleep timer, sleep and wake, watchdog and power-on
`timescale 1ns/1ns
module reset_watchdog_sleep_ctrl_test import rst_wdt_pkg::*; ;
  logic sys_clk = 1'b0, reset = 1'b1, slowTick = 1'b0, supplyBelowPor = 1'b0;
  logic irqPending = 1'b0, globalIrqEnable = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] pwdata = 8'h00, v;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] prdata, rd, rnd = 32'h0000004E;
  logic pready, pslverr, cpuReset, cpuRun, resumeNext, cpuClockSelect, extOscEnable, err, d0;
  logic slowOscLowPower, sleepTimerIrq, detectorOn, precisionResetEnable;
  logic [1:0] precisionResetLevel;
  logic [2:0] lvdThresholdSelect, tcnt = 3'h0;
  int failures = 0, compares = 0, n;
  reset_watchdog_sleep_ctrl #(.HOLDOFF(20), .TIMER_W(16)) uut (.*);
  // clock, and a slow tick every eight clocks
  always #20 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    tcnt <= tcnt + 3'h1;
    slowTick <= tcnt[2];
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function automatic logic sig(input int w);
    case (w)
      0: return cpuReset;
      1: return sleepTimerIrq;
      2: return detectorOn;
      default: return resumeNext;
    endcase
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic ok(input logic c);
    check({31'h0, c}, 32'h1);
  endtask
  task automatic finish_test;
    $display("failures %0d compares %0d", failures, compares);
    if (failures == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // bounded wait for a level, counting edges in n
  task automatic waitSig(input int w, input logic lvl, input int max);
    n = 0;
    while (sig(w) !== lvl && n < max) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= max) begin
      failures++;
      finish_test;
    end
  endtask
  // one apb transfer; result left in rd and err
  task automatic apb(input logic wr, input logic [13:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'b00, a};
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      failures++;
      finish_test;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  initial begin
    repeat (90000) @(posedge sys_clk);
    failures++;
    finish_test;
  end
  initial begin
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    waitSig(0, 1'b0, 100);
    ok(n > 18 && n < 25);
    apb(1'b0, ADDR_SYSTEM_STATUS_CONTROL, 8'h00);
    check(rd, 32'h90);
    for (int i = 0; i < 10; i++) begin
      rnd = xs(rnd);
      v = (i == 0) ? 8'hFF : (i == 1) ? 8'h30 : rnd[7:0];
      apb(1'b1, ADDR_LOW_VOLTAGE_CONTROL, v);
      apb(1'b0, ADDR_LOW_VOLTAGE_CONTROL, 8'h00);
      check(rd, {24'h0, v & LVC_MASK});
      ok(precisionResetLevel === v[5:4] && lvdThresholdSelect === v[2:0]);
      ok(precisionResetEnable === (v[5:4] != 2'b11));
    end
    apb(1'b0, 14'h0004, 8'h00);
    ok(err === 1'b1 && rd === 32'h0);
    waitSig(1, 1'b1, 3000);
    @(posedge sys_clk);
    waitSig(1, 1'b1, 3000);
    check(n, 2047);
    apb(1'b1, ADDR_OSC_CONTROL_ZERO, 8'h86);
    apb(1'b1, ADDR_DETECTOR_DUTY_TRIM, 8'hC0);
    ok(cpuClockSelect === 1'b1 && extOscEnable === 1'b1);
    globalIrqEnable <= 1'b0;
    apb(1'b1, ADDR_SYSTEM_STATUS_CONTROL, 8'h19);
    repeat (4) @(posedge sys_clk);
    ok(cpuRun === 1'b0 && cpuClockSelect === 1'b0);
    ok(extOscEnable === 1'b1 && slowOscLowPower === 1'b1);
    waitSig(2, ~detectorOn, 200);
    d0 = detectorOn;
    @(posedge sys_clk);
    waitSig(2, ~d0, 200);
    check(n, 63);
    irqPending <= 1'b1;
    repeat (200) @(posedge sys_clk);
    ok(cpuRun === 1'b0);
    apb(1'b1, ADDR_SYSTEM_STATUS_CONTROL, 8'h18);
    waitSig(3, 1'b1, 100);
    ok(n < 48 && cpuRun === 1'b1);
    irqPending <= 1'b0;
    apb(1'b0, ADDR_SYSTEM_STATUS_CONTROL, 8'h00);
    check(rd, 32'h10);
    apb(1'b1, ADDR_SYSTEM_STATUS_CONTROL, 8'h00);
    apb(1'b1, ADDR_WATCHDOG_CLEAR, CLEAR_BOTH_CODE);
    apb(1'b1, ADDR_SYSTEM_STATUS_CONTROL, 8'h10);
    apb(1'b0, ADDR_SYSTEM_STATUS_CONTROL, 8'h00);
    check(rd, 32'h00);
    for (int i = 0; i < 4; i++) begin
      repeat (1900) @(posedge sys_clk);
      rnd = xs(rnd);
      apb(1'b1, ADDR_WATCHDOG_CLEAR, rnd[7:0]);
    end
    apb(1'b0, ADDR_WAKE_STATUS, 8'h00);
    ok(rd[3] === 1'b1 && cpuReset === 1'b0);
    apb(1'b1, ADDR_WATCHDOG_CLEAR, CLEAR_BOTH_CODE);
    apb(1'b0, ADDR_WAKE_STATUS, 8'h00);
    check(rd & 32'h6, 32'h0);
    waitSig(0, 1'b1, 6400);
    ok(n > 6100 && n < 6200);
    apb(1'b0, ADDR_SYSTEM_STATUS_CONTROL, 8'h00);
    check(rd, 32'h20);
    supplyBelowPor <= 1'b1;
    repeat (6) @(posedge sys_clk);
    supplyBelowPor <= 1'b0;
    repeat (6) @(posedge sys_clk);
    apb(1'b0, ADDR_SYSTEM_STATUS_CONTROL, 8'h00);
    check(rd, 32'h10);
    apb(1'b0, ADDR_WAKE_STATUS, 8'h00);
    check(rd, 32'h0);
    finish_test;
  end
endmodule
